/* pkg/dbgpm_regs.vh */
// register offsets, field positions and reset values of the data bus pad mux
`ifndef DBGPM_REGS_VH
`define DBGPM_REGS_VH
`define DBGPM_ADDR_W 8
`define DBGPM_OFS_BUS_CTRL 8'h00
`define DBGPM_OFS_PF_FUNC 8'h04
`define DBGPM_OFS_PF_DIR 8'h08
`define DBGPM_OFS_PF_DATA 8'h0c
`define DBGPM_OFS_PF_PULLUP 8'h10
`define DBGPM_OFS_PF_LEVEL 8'h14
`define DBGPM_OFS_BUS_STAT 8'h18
`define DBGPM_BIT_DRIVE_HOLD 0
`define DBGPM_BIT_BUS_ACTIVE 0
`define DBGPM_PF_LSB 9
`define DBGPM_PF_MSB 15
`define DBGPM_NUM_SHARED 7
`define DBGPM_NUM_LINES 16
`define DBGPM_RST_BUS_CTRL 1'h0
`define DBGPM_RST_PF_FUNC 7'h7f
`define DBGPM_RST_PF_DIR 7'h00
`define DBGPM_RST_PF_DATA 7'h00
`define DBGPM_RST_PF_PULLUP 7'h7f
`endif

/* rtl/dbgpm_pad_cell.v */
// one data line pad: output, enable and pull-up flip-flops plus function select
`timescale 1ns/10ps
module dbgpm_pad_cell (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire gpio_sel,
   input wire gpio_dir,
   input wire gpio_val,
   input wire pu_en,
   input wire bus_drive,
   input wire bus_val,
   output reg pad_out_ff,
   output reg pad_oe_ff,
   output reg pad_pu_ff
);
   reg nxt_pad_out;
   reg nxt_pad_oe;

   always @* begin
      if (gpio_sel) begin
         nxt_pad_oe = gpio_dir;
         nxt_pad_out = gpio_val;
      end else begin
         nxt_pad_oe = bus_drive;
         nxt_pad_out = bus_val;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out_ff <= 1'b0;
         pad_oe_ff <= 1'b0;
         pad_pu_ff <= 1'b1;
      end else if (clk_en) begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_ff <= nxt_pad_oe;
         pad_pu_ff <= pu_en;
      end
   end
endmodule

/* rtl/dbgpm_pad_mux.v */
// data bus / port f pad multiplexer with apb register slave
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dbgpm_regs.vh"

// Notes on behaviour
// - bus function: lines 0..6 carry data word bits 0..6 for memory accesses.
// - lines 7..15 carry the upper data word bits for memory accesses.
// - idle bus: lines float, or stay driven when drive-hold is set.
// - each shared port f pin is input or output by its own bit.
// - after reset, shared pins are in data bus function.
// - clearing pull-up register bit n turns off pull-up of port pin n.
// - every shared pin has a pull-up controlled per pin.
module dbgpm_pad_mux (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_ff,
   output reg pready_ff,
   output reg pslverr_ff,
   input wire emi_active,
   input wire emi_write,
   input wire [15:0] emi_wdata,
   output reg [15:0] emi_rdata_ff,
   input wire [15:0] pad_in,
   output wire [15:0] pad_out,
   output wire [15:0] pad_oe,
   output wire [15:0] pad_pu
);
   localparam NS = `DBGPM_NUM_SHARED;
   localparam NL = `DBGPM_NUM_LINES;

   reg drive_hold_ff;
   reg [NS-1:0] pf_func_ff;
   reg [NS-1:0] pf_dir_ff;
   reg [NS-1:0] pf_data_ff;
   reg [NS-1:0] pf_pullup_ff;
   reg [NS-1:0] pf_level_ff;
   reg bus_active_ff;
   reg [NL-1:0] bus_val_ff;
   reg [31:0] nxt_prdata;
   reg nxt_slverr;
   reg bus_drive;
   wire access;
   wire wr_en;
   wire [NS-1:0] wr_field;
   reg nxt_drive_hold;
   reg [NS-1:0] nxt_pf_func;
   reg [NS-1:0] nxt_pf_dir;
   reg [NS-1:0] nxt_pf_data;
   reg [NS-1:0] nxt_pf_pullup;

   // true for every offset this slave implements
   function addr_mapped;
      input [7:0] a;
      begin
         case (a)
            `DBGPM_OFS_BUS_CTRL: addr_mapped = 1'b1;
            `DBGPM_OFS_PF_FUNC: addr_mapped = 1'b1;
            `DBGPM_OFS_PF_DIR: addr_mapped = 1'b1;
            `DBGPM_OFS_PF_DATA: addr_mapped = 1'b1;
            `DBGPM_OFS_PF_PULLUP: addr_mapped = 1'b1;
            `DBGPM_OFS_PF_LEVEL: addr_mapped = 1'b1;
            `DBGPM_OFS_BUS_STAT: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
         endcase
      end
   endfunction

   // place a shared-pin field at port f bit positions 15:9
   function [31:0] pf_field;
      input [NS-1:0] v;
      begin
         pf_field = {16'h0000, v, 9'h000};
      end
   endfunction

   assign access = psel & penable & ~pready_ff;
   assign wr_en = psel & penable & pready_ff & pwrite & addr_mapped(paddr);
   // port f field of the write data, bits 15:9
   assign wr_field = pwdata[`DBGPM_PF_MSB:`DBGPM_PF_LSB];

   always @* begin
      nxt_slverr = ~addr_mapped(paddr);
      case (paddr)
         `DBGPM_OFS_BUS_CTRL: nxt_prdata = {31'h0, drive_hold_ff};
         `DBGPM_OFS_PF_FUNC: nxt_prdata = pf_field(pf_func_ff);
         `DBGPM_OFS_PF_DIR: nxt_prdata = pf_field(pf_dir_ff);
         `DBGPM_OFS_PF_DATA: nxt_prdata = pf_field(pf_data_ff);
         `DBGPM_OFS_PF_PULLUP: nxt_prdata = pf_field(pf_pullup_ff);
         `DBGPM_OFS_PF_LEVEL: nxt_prdata = pf_field(pf_level_ff);
         `DBGPM_OFS_BUS_STAT: nxt_prdata = {31'h0, bus_active_ff};
         default: nxt_prdata = 32'h00000000;
      endcase
      if (pwrite)
         nxt_prdata = 32'h00000000;
   end

   // clk_en low also freezes pready_ff: keep clk_en high through an apb transfer,
   // or a write the master completes during the freeze is lost
   // apb answer: one wait state, pready on the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else if (clk_en) begin
         pready_ff <= access;
         if (access) begin
            pslverr_ff <= nxt_slverr;
            prdata_ff <= nxt_prdata;
         end else begin
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
         end
      end
   end

   // software register next values; only a completed mapped write changes them
   always @* begin
      nxt_drive_hold = drive_hold_ff;
      nxt_pf_func = pf_func_ff;
      nxt_pf_dir = pf_dir_ff;
      nxt_pf_data = pf_data_ff;
      nxt_pf_pullup = pf_pullup_ff;
      if (wr_en) begin
         case (paddr)
            `DBGPM_OFS_BUS_CTRL: nxt_drive_hold = pwdata[`DBGPM_BIT_DRIVE_HOLD];
            `DBGPM_OFS_PF_FUNC: nxt_pf_func = wr_field;
            `DBGPM_OFS_PF_DIR: nxt_pf_dir = wr_field;
            `DBGPM_OFS_PF_DATA: nxt_pf_data = wr_field;
            `DBGPM_OFS_PF_PULLUP: nxt_pf_pullup = wr_field;
            default: nxt_drive_hold = drive_hold_ff;
         endcase
      end
   end

   // software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_hold_ff <= `DBGPM_RST_BUS_CTRL;
         pf_func_ff <= `DBGPM_RST_PF_FUNC;
         pf_dir_ff <= `DBGPM_RST_PF_DIR;
         pf_data_ff <= `DBGPM_RST_PF_DATA;
         pf_pullup_ff <= `DBGPM_RST_PF_PULLUP;
      end else if (clk_en) begin
         drive_hold_ff <= nxt_drive_hold;
         pf_func_ff <= nxt_pf_func;
         pf_dir_ff <= nxt_pf_dir;
         pf_data_ff <= nxt_pf_data;
         pf_pullup_ff <= nxt_pf_pullup;
      end
   end

   // sampled pin levels and memory-side data capture
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_level_ff <= {NS{1'b0}};
         bus_active_ff <= 1'b0;
         bus_val_ff <= 16'h0000;
         emi_rdata_ff <= 16'h0000;
      end else if (clk_en) begin
         pf_level_ff <= pad_in[NS-1:0];
         bus_active_ff <= emi_active;
         if (emi_active && emi_write)
            bus_val_ff <= emi_wdata;
         if (emi_active && !emi_write)
            emi_rdata_ff <= pad_in;
      end
   end

   // write cycles drive the lines; idle bus keeps last value only with drive-hold
   always @* begin
      if (emi_active)
         bus_drive = emi_write;
      else
         bus_drive = drive_hold_ff;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NL; gi = gi + 1) begin : g_line
         wire sel;
         wire dir;
         wire val;
         wire pu;
         wire bval;
         if (gi < NS) begin : g_shared
            assign sel = ~pf_func_ff[gi];
            assign dir = pf_dir_ff[gi];
            assign val = pf_data_ff[gi];
            assign pu = pf_pullup_ff[gi];
         end else begin : g_bus_only
            assign sel = 1'b0;
            assign dir = 1'b0;
            assign val = 1'b0;
            assign pu = 1'b1;
         end
         assign bval = (emi_active && emi_write) ? emi_wdata[gi] : bus_val_ff[gi];
         dbgpm_pad_cell u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .gpio_sel(sel),
            .gpio_dir(dir),
            .gpio_val(val),
            .pu_en(pu),
            .bus_drive(bus_drive),
            .bus_val(bval),
            .pad_out_ff(pad_out[gi]),
            .pad_oe_ff(pad_oe[gi]),
            .pad_pu_ff(pad_pu[gi])
         );
      end
   endgenerate
endmodule

/* tb/dbgpm_pad_mux_props.sv */
// assertions on the ports of the data bus pad mux
`timescale 1ns/10ps
module dbgpm_pad_mux_props (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pready_ff,
   input wire pslverr_ff,
   input wire emi_active,
   input wire emi_write,
   input wire [15:0] emi_wdata,
   input wire [15:0] emi_rdata_ff,
   input wire [15:0] pad_in,
   input wire [15:0] pad_out,
   input wire [15:0] pad_oe,
   input wire [15:0] pad_pu
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   bus_write_a: assert property (clk_en && emi_active && emi_write |=>
      pad_oe[15:7] == 9'h1ff && pad_out[15:7] == $past(emi_wdata[15:7])) else $error("bad write");
   idle_float_a: assert property (clk_en && !emi_active |=>
      pad_oe[15:7] == 9'h000 || pad_oe[15:7] == 9'h1ff) else $error("bad idle enable");
   idle_hold_a: assert property (clk_en && !emi_active |=> $stable(pad_out[15:7]))
      else $error("idle data moved");
   read_capture_a: assert property (clk_en && emi_active && !emi_write |=>
      emi_rdata_ff == $past(pad_in)) else $error("bad read capture");
   reset_pads_a: assert property (disable iff (1'b0) !presetn |->
      pad_oe == 16'h0000 && pad_pu == 16'hffff) else $error("bad reset pads");
   upper_pullup_a: assert property (pad_pu[15:7] == 9'h1ff) else $error("pull-up off");
   apb_ready_a: assert property (clk_en && psel && penable && !pready_ff |=> pready_ff)
      else $error("no ready");
   ready_pulse_a: assert property (pready_ff && clk_en |=> !pready_ff)
      else $error("ready too long");
   cover property (emi_active && emi_write);
   cover property (emi_active && !emi_write);
   cover property (pslverr_ff);
   cover property (!clk_en && emi_active && emi_write);
endmodule
bind dbgpm_pad_mux dbgpm_pad_mux_props chk_u (.pclk, .presetn, .clk_en, .psel, .penable,
   .pready_ff, .pslverr_ff, .emi_active, .emi_write, .emi_wdata, .emi_rdata_ff, .pad_in,
   .pad_out, .pad_oe, .pad_pu);

/* tb/dbgpm_mem_model.sv */
// external memory on the data lines, with line resolution
`timescale 1ns/10ps
module dbgpm_mem_model (
   input wire pclk,
   input wire mem_oe,
   input wire [15:0] mem_q,
   input wire [15:0] pad_out,
   input wire [15:0] pad_oe,
   input wire [15:0] pad_pu,
   output wire [15:0] pad_in
);
   reg [15:0] last_ff = 16'h0000;
   // floating line without pull-up shows the inverse of its last level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & {16{mem_oe}} & mem_q)
      | (~pad_oe & ~{16{mem_oe}} & (pad_pu | ~last_ff));
   always @(posedge pclk) last_ff <= pad_in;
endmodule

/* tb/testbench.sv */
// self-checking bench of the data bus pad mux
`timescale 1ns/10ps
module testbench;
   reg pclk = 0, presetn = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg emi_active = 0, emi_write = 0, mem_oe = 0;
   reg [15:0] emi_wdata = 16'h0, mem_q = 16'h3c5a;
   wire [31:0] prdata_ff;
   wire pready_ff, pslverr_ff;
   wire [15:0] emi_rdata_ff, pad_in, pad_out, pad_oe, pad_pu;
   integer mismatches = 0, checked = 0;
   always #5 pclk = ~pclk;
   dbgpm_pad_mux dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
      .emi_active(emi_active), .emi_write(emi_write), .emi_wdata(emi_wdata),
      .emi_rdata_ff(emi_rdata_ff), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pu(pad_pu));
   dbgpm_mem_model mem_u (.pclk(pclk), .mem_oe(mem_oe), .mem_q(mem_q), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_in(pad_in));
   task report_and_stop;
      begin
         $display("checked %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         checked++;
         if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // one apb transfer; reads compare data, both compare the error flag
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
      integer n;
      begin
         n = 0;
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
         @(posedge pclk) penable <= 1;
         do begin
            @(posedge pclk);
            n++;
         end while (pready_ff !== 1'b1 && n < 20);
         if (pready_ff !== 1'b1) begin
            mismatches++;
            report_and_stop;
         end
         if (!w) chk(prdata_ff, err ? 32'h0 : d);
         chk({31'h0, pslverr_ff}, {31'h0, err});
         psel <= 0; penable <= 0;
         @(posedge pclk);
      end
   endtask
   initial begin
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(pad_oe, 16'h0000); chk(pad_pu, 16'hffff);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 8'h04, 32'hfe00, 0);
      apb(0, 8'h10, 32'hfe00, 0);
      apb(0, 8'h00, 32'h0, 0);
      apb(0, 8'h1c, 32'h0, 1);
      emi_active <= 1; emi_write <= 1; emi_wdata <= 16'ha5c3;
      @(posedge pclk) emi_active <= 0;
      @(posedge pclk) chk(pad_out, 16'ha5c3); chk(pad_oe, 16'hffff);
      @(posedge pclk) chk(pad_oe, 16'h0000);
      mem_oe <= 1; emi_active <= 1; emi_write <= 0;
      repeat (2) @(posedge pclk);
      mem_oe <= 0; emi_active <= 0;
      @(posedge pclk) chk(emi_rdata_ff, 16'h3c5a);
      apb(1, 8'h00, 32'h1, 0);
      repeat (2) @(posedge pclk);
      chk(pad_oe, 16'hffff); chk(pad_out, 16'ha5c3);
      apb(1, 8'h04, 32'h0, 0);
      apb(1, 8'h08, 32'h5400, 0);
      apb(1, 8'h0c, 32'h0, 0);
      repeat (2) @(posedge pclk);
      chk(pad_oe, 16'hffaa); chk(pad_out & 16'h002a, 16'h0);
      apb(0, 8'h14, 32'haa00, 0);
      apb(1, 8'h0c, 32'h5400, 0);
      repeat (2) @(posedge pclk);
      chk(pad_out & 16'h002a, 16'h002a);
      apb(1, 8'h10, 32'hfc00, 0);
      repeat (2) @(posedge pclk);
      chk(pad_pu, 16'hfffe);
      apb(0, 8'h10, 32'hfc00, 0);
      // frozen by clk_en: a memory write must not reach the lines
      clk_en <= 0; emi_active <= 1; emi_write <= 1; emi_wdata <= 16'h1234;
      repeat (2) @(posedge pclk);
      chk(pad_out & 16'hff80, 16'ha580); chk(pad_oe, 16'hffaa);
      clk_en <= 1;
      @(posedge pclk) emi_active <= 0;
      @(posedge pclk) chk(pad_out & 16'hff80, 16'h1200);
      report_and_stop;
   end
endmodule
